// file: design/drive_fault_annunciator.sv
// Drive status display sequencing and warning/error annunciation
//
// Summary of operation
// - At power-up show firmware version, after one second the status.
// - Auxiliary supply only: show current rating, dot flashing.
// - Mains present, not enabled: show mains-ready status, dot flashing.
// - Mains present and enabled: show enabled status, dot flashing.
// - Warnings keep drive enabled and fault relay closed.
// - Each digital output can be set to assert on any warning.
// - An active warning is shown as its code on the display.
// - n01 i2t, n02 regen power, n03 following error, thresholds set.
// - n06/n07 software limits, n10/n11 hardware limit switches.
// - n08 faulty motion task, n09 motion without home reference.
// - n05 missing mains phase unless suppressed for single phase.
// - n04 fieldbus monitor, n12 encoder defaults, n14, n15 table error.
// - n13, n16..n31 reserved; n32 beta firmware; A reset on input.
// - Errors disable drive, apply brake and open fault relay.
// - Digital outputs can assert on errors; error code is displayed.
// - F01 heat sink, F02 overvoltage, F03 following, F04 feedback.
// - F05 when DC link is under 100 V as the drive is enabled.
// - F23 when the CAN bus goes bus-off.
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns
module drive_fault_annunciator #(
  parameter int         VERSION_CYCLES = annunciator_pkg::VERSION_CYCLES,
  parameter int         FLASH_CYCLES   = annunciator_pkg::FLASH_CYCLES,
  // Arbitrary firmware version value
  parameter logic [7:0] FW_VERSION     = 8'h11,
  parameter logic [7:0] CURRENT_RATING = 8'h01
) (
  input  wire logic                                 clk,
  input  wire logic                                 reset,
  input  wire logic [annunciator_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [annunciator_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                                 reg_wr,
  input  wire logic                                 reg_rd,
  output logic      [annunciator_pkg::DATA_W-1:0]   reg_rdata,
  input  wire logic                                 mains_on,
  input  wire logic                                 enable_in,
  input  wire logic [15:0]                          dc_link_volts,
  input  annunciator_pkg::meas_t                    meas,
  input  annunciator_pkg::warn_src_t                warn_src,
  input  annunciator_pkg::err_src_t                 err_src,
  output annunciator_pkg::display_t                 display,
  output logic                                      drive_enabled,
  output logic                                      brake_applied,
  output logic                                      fault_relay_closed,
  output logic      [1:0]                           dig_out
);

  typedef enum logic [0:0] {
    BOOT_VERSION = 1'b0,
    BOOT_RUN     = 1'b1
  } boot_t;

  typedef struct packed {
    boot_t                                 boot;
    logic [annunciator_pkg::CNT_W-1:0]     boot_cnt;
    logic [annunciator_pkg::CNT_W-1:0]     flash_cnt;
    logic                                  dot_on;
    logic [annunciator_pkg::CTRL_W-1:0]    ctrl;
    logic [15:0]                           thr_i2t;
    logic [15:0]                           thr_regen;
    logic [15:0]                           thr_follow;
    logic [15:0]                           lim_follow;
    logic [annunciator_pkg::ERR_N-1:0]     err_latch;
    logic                                  enable_prev;
    logic [annunciator_pkg::DATA_W-1:0]    rdata;
    annunciator_pkg::display_t             disp;
    logic                                  drive_en;
    logic                                  brake;
    logic                                  relay_closed;
    logic [1:0]                            dout;
  } state_t;

  state_t                                  state_q;
  state_t                                  state_d;
  logic [annunciator_pkg::WARN_N-1:0]      warn_vec;
  logic [annunciator_pkg::ERR_N-1:0]       err_set;
  logic [annunciator_pkg::ERR_N-1:0]       err_next;
  annunciator_pkg::display_t               status_disp;
  annunciator_pkg::display_t               shown_disp;
  logic                                    any_warn;
  logic                                    any_err;
  logic                                    run_en;

  localparam logic [annunciator_pkg::CNT_W-1:0] BOOT_LAST =
    annunciator_pkg::CNT_W'(VERSION_CYCLES - 1);
  localparam logic [annunciator_pkg::CNT_W-1:0] FLASH_LAST =
    annunciator_pkg::CNT_W'(FLASH_CYCLES - 1);

  // Warning vector indexed by code number; reserved codes stay zero
  always_comb begin
    warn_vec = '0;
    warn_vec[annunciator_pkg::W_I2T]    = meas.i2t > state_q.thr_i2t;
    warn_vec[annunciator_pkg::W_REGEN]  = meas.regen > state_q.thr_regen;
    warn_vec[annunciator_pkg::W_FOLLOW] = meas.follow > state_q.thr_follow;
    warn_vec[annunciator_pkg::W_RESP_MON] = warn_src.resp_monitor;
    warn_vec[annunciator_pkg::W_ENC_DEF]  = warn_src.enc_defaults;
    warn_vec[annunciator_pkg::W_ENC_REF]  = warn_src.enc_ref_reset;
    warn_vec[annunciator_pkg::W_VC_TABLE] = warn_src.vc_table_err;
    warn_vec[annunciator_pkg::W_PHASE] = warn_src.phase_missing &
      ~state_q.ctrl[annunciator_pkg::CTRL_PHASE_SUPPRESS];
    warn_vec[annunciator_pkg::W_SW_LIM1] = warn_src.sw_limit1;
    warn_vec[annunciator_pkg::W_SW_LIM2] = warn_src.sw_limit2;
    warn_vec[annunciator_pkg::W_POS_LIM] = warn_src.pos_limit;
    warn_vec[annunciator_pkg::W_NEG_LIM] = warn_src.neg_limit;
    warn_vec[annunciator_pkg::W_MOTION]  = warn_src.motion_fault;
    warn_vec[annunciator_pkg::W_NO_HOME] = warn_src.no_home;
    warn_vec[annunciator_pkg::W_BETA] = warn_src.beta_firmware;
  end

  // Errors are sticky until software clears them
  always_comb begin
    err_set = '0;
    err_set[annunciator_pkg::E_HEAT_SINK] = err_src.heat_sink_ot;
    err_set[annunciator_pkg::E_DC_OVER]   = err_src.dc_overvolt;
    err_set[annunciator_pkg::E_FOLLOW]    = meas.follow > state_q.lim_follow;
    err_set[annunciator_pkg::E_FEEDBACK]  = err_src.feedback_bad;
    err_set[annunciator_pkg::E_DC_UNDER]  = enable_in &
      ~state_q.enable_prev &
      (dc_link_volts < annunciator_pkg::DC_LINK_MIN_V);
    err_set[annunciator_pkg::E_CAN_OFF]   = err_src.can_bus_off;
  end

  // Kept apart from the state update so no process reads its own output
  // Write one to clear; a fault present in the same cycle stays latched
  always_comb begin
    err_next = state_q.err_latch | err_set;
    if (reg_wr && reg_addr == annunciator_pkg::REG_ERRORS) begin
      err_next = (state_q.err_latch &
        ~reg_wdata[annunciator_pkg::ERR_N-1:0]) | err_set;
    end
  end

  assign any_warn = (warn_vec != '0) | warn_src.reset_on_input;
  assign any_err  = err_next != '0;

  // Power status shown when no code is pending
  always_comb begin
    status_disp.dot = state_q.dot_on;
    if (state_q.boot == BOOT_VERSION) begin
      status_disp.kind = annunciator_pkg::DISP_VERSION;
      status_disp.num  = FW_VERSION;
      status_disp.dot  = 1'b0;
    end else if (!mains_on) begin
      status_disp.kind = annunciator_pkg::DISP_RATING;
      status_disp.num  = CURRENT_RATING;
    end else if (!state_q.drive_en) begin
      status_disp.kind = annunciator_pkg::DISP_MAINS_READY;
      status_disp.num  = 8'h00;
    end else begin
      status_disp.kind = annunciator_pkg::DISP_ENABLED;
      status_disp.num  = 8'h00;
    end
  end

  code_selector u_select (
    .status     (status_disp),
    .warn_vec   (warn_vec),
    .reset_warn (warn_src.reset_on_input),
    .err_vec    (state_q.err_latch),
    .shown      (shown_disp)
  );

  // Drive runs only after boot; the controller is trusted for mains timing
  // enable gated by mains
  assign run_en = enable_in & mains_on & (state_q.boot == BOOT_RUN);

  always_comb begin
    state_d = state_q;

    if (state_q.boot == BOOT_VERSION) begin
      if (state_q.boot_cnt == BOOT_LAST) begin
        state_d.boot = BOOT_RUN;
      end else begin
        state_d.boot_cnt = state_q.boot_cnt + 1'b1;
      end
    end

    if (state_q.flash_cnt == FLASH_LAST) begin
      state_d.flash_cnt = '0;
      state_d.dot_on    = ~state_q.dot_on;
    end else begin
      state_d.flash_cnt = state_q.flash_cnt + 1'b1;
    end

    state_d.enable_prev = enable_in;

    // Register writes
    if (reg_wr) begin
      if (reg_addr == annunciator_pkg::REG_CTRL) begin
        state_d.ctrl = reg_wdata[annunciator_pkg::CTRL_W-1:0];
      end else if (reg_addr == annunciator_pkg::REG_THR_I2T) begin
        state_d.thr_i2t = reg_wdata[15:0];
      end else if (reg_addr == annunciator_pkg::REG_THR_REGEN) begin
        state_d.thr_regen = reg_wdata[15:0];
      end else if (reg_addr == annunciator_pkg::REG_THR_FOLLOW) begin
        state_d.thr_follow = reg_wdata[15:0];
      end else if (reg_addr == annunciator_pkg::REG_LIM_FOLLOW) begin
        state_d.lim_follow = reg_wdata[15:0];
      end
    end

    // Set wins over a clear in the same cycle
    state_d.err_latch = err_next;

    state_d.drive_en     = run_en & (err_next == '0);
    state_d.brake        = ~state_d.drive_en;
    state_d.relay_closed = ~any_err;

    state_d.dout[0] =
      (state_q.ctrl[annunciator_pkg::CTRL_DOUT0_WARN] & any_warn) |
      (state_q.ctrl[annunciator_pkg::CTRL_DOUT0_ERR]  & any_err);
    state_d.dout[1] =
      (state_q.ctrl[annunciator_pkg::CTRL_DOUT1_WARN] & any_warn) |
      (state_q.ctrl[annunciator_pkg::CTRL_DOUT1_ERR]  & any_err);

    state_d.disp = shown_disp;

    // Read data stands only in the cycle after the strobe
    state_d.rdata = '0;
    if (reg_rd) begin
      if (reg_addr == annunciator_pkg::REG_CTRL) begin
        state_d.rdata = 32'(state_q.ctrl);
      end else if (reg_addr == annunciator_pkg::REG_THR_I2T) begin
        state_d.rdata = 32'(state_q.thr_i2t);
      end else if (reg_addr == annunciator_pkg::REG_THR_REGEN) begin
        state_d.rdata = 32'(state_q.thr_regen);
      end else if (reg_addr == annunciator_pkg::REG_THR_FOLLOW) begin
        state_d.rdata = 32'(state_q.thr_follow);
      end else if (reg_addr == annunciator_pkg::REG_LIM_FOLLOW) begin
        state_d.rdata = 32'(state_q.lim_follow);
      end else if (reg_addr == annunciator_pkg::REG_WARNINGS) begin
        state_d.rdata = warn_vec[32:1];
      end else if (reg_addr == annunciator_pkg::REG_ERRORS) begin
        state_d.rdata = 32'(state_q.err_latch);
      end else if (reg_addr == annunciator_pkg::REG_DISPLAY) begin
        state_d.rdata = 32'(state_q.disp);
      end else if (reg_addr == annunciator_pkg::REG_OUTPUTS) begin
        state_d.rdata = {27'h0000000, warn_src.reset_on_input,
                         state_q.dout, state_q.relay_closed,
                         state_q.drive_en};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q              <= '0;
      state_q.boot         <= BOOT_VERSION;
      state_q.ctrl         <= annunciator_pkg::CTRL_RESET;
      state_q.thr_i2t      <= annunciator_pkg::THR_RESET;
      state_q.thr_regen    <= annunciator_pkg::THR_RESET;
      state_q.thr_follow   <= annunciator_pkg::THR_RESET;
      state_q.lim_follow   <= annunciator_pkg::THR_RESET;
      state_q.brake        <= 1'b1;
      state_q.relay_closed <= 1'b1;
      state_q.disp.kind    <= annunciator_pkg::DISP_VERSION;
      state_q.disp.num     <= FW_VERSION;
    end else begin
      state_q <= state_d;
    end
  end

  assign reg_rdata          = state_q.rdata;
  assign display            = state_q.disp;
  assign drive_enabled      = state_q.drive_en;
  assign brake_applied      = state_q.brake;
  assign fault_relay_closed = state_q.relay_closed;
  assign dig_out            = state_q.dout;

endmodule

// file: shared/annunciator_pkg.sv
// Shared constants, register map and carrier types for the annunciator
package annunciator_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 4;

  // Register offsets on the plain register port
  localparam logic [ADDR_W-1:0] REG_CTRL        = 4'h0;
  localparam logic [ADDR_W-1:0] REG_THR_I2T     = 4'h1;
  localparam logic [ADDR_W-1:0] REG_THR_REGEN   = 4'h2;
  localparam logic [ADDR_W-1:0] REG_THR_FOLLOW  = 4'h3;
  localparam logic [ADDR_W-1:0] REG_LIM_FOLLOW  = 4'h4;
  localparam logic [ADDR_W-1:0] REG_WARNINGS    = 4'h5;
  localparam logic [ADDR_W-1:0] REG_ERRORS      = 4'h6;
  localparam logic [ADDR_W-1:0] REG_DISPLAY     = 4'h7;
  localparam logic [ADDR_W-1:0] REG_OUTPUTS     = 4'h8;

  // Control register fields
  localparam int CTRL_PHASE_SUPPRESS = 0;
  localparam int CTRL_DOUT0_WARN     = 1;
  localparam int CTRL_DOUT0_ERR      = 2;
  localparam int CTRL_DOUT1_WARN     = 3;
  localparam int CTRL_DOUT1_ERR      = 4;
  localparam int CTRL_W              = 5;

  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
  localparam logic [15:0]       THR_RESET  = 16'hffff;

  // Timing
  localparam int CLK_HZ          = 10_000_000;
  localparam int VERSION_TIME_MS = 1000;
  localparam int VERSION_CYCLES  = CLK_HZ / 1000 * VERSION_TIME_MS;
  localparam int FLASH_HALF_MS   = 500;
  localparam int FLASH_CYCLES    = CLK_HZ / 1000 * FLASH_HALF_MS;
  localparam int CNT_W           = 24;
  // Settling time the controller must leave after mains on
  localparam int MAINS_SETTLE_MS = 500;

  // Least DC link voltage at enable, in volts
  localparam logic [15:0] DC_LINK_MIN_V = 16'h0064;

  // Warning code numbers (index into the warning vector)
  localparam int WARN_N       = 33;
  localparam int W_I2T        = 1;
  localparam int W_REGEN      = 2;
  localparam int W_FOLLOW     = 3;
  localparam int W_RESP_MON   = 4;
  localparam int W_PHASE      = 5;
  localparam int W_SW_LIM1    = 6;
  localparam int W_SW_LIM2    = 7;
  localparam int W_MOTION     = 8;
  localparam int W_NO_HOME    = 9;
  localparam int W_POS_LIM    = 10;
  localparam int W_NEG_LIM    = 11;
  localparam int W_ENC_DEF    = 12;
  localparam int W_ENC_REF    = 14;
  localparam int W_VC_TABLE   = 15;
  localparam int W_BETA       = 32;

  // Error code numbers (index into the error vector)
  localparam int ERR_N        = 24;
  localparam int E_HEAT_SINK  = 1;
  localparam int E_DC_OVER    = 2;
  localparam int E_FOLLOW     = 3;
  localparam int E_FEEDBACK   = 4;
  localparam int E_DC_UNDER   = 5;
  localparam int E_CAN_OFF    = 23;

  typedef enum logic [2:0] {
    DISP_VERSION     = 3'b000,
    DISP_RATING      = 3'b001,
    DISP_MAINS_READY = 3'b010,
    DISP_ENABLED     = 3'b011,
    DISP_WARNING     = 3'b100,
    DISP_ERROR       = 3'b101,
    DISP_RESET_IN    = 3'b110
  } disp_kind_t;

  typedef struct packed {
    disp_kind_t  kind;
    logic [7:0]  num;
    logic        dot;
  } display_t;

  typedef struct packed {
    logic resp_monitor;
    logic phase_missing;
    logic sw_limit1;
    logic sw_limit2;
    logic motion_fault;
    logic no_home;
    logic pos_limit;
    logic neg_limit;
    logic enc_defaults;
    logic enc_ref_reset;
    logic vc_table_err;
    logic beta_firmware;
    logic reset_on_input;
  } warn_src_t;

  typedef struct packed {
    logic heat_sink_ot;
    logic dc_overvolt;
    logic feedback_bad;
    logic can_bus_off;
  } err_src_t;

  typedef struct packed {
    logic [15:0] i2t;
    logic [15:0] regen;
    logic [15:0] follow;
  } meas_t;

endpackage

// file: design/code_selector.sv
// Chooses what the front panel shows: error, warning or power status
`timescale 1ns/1ns
module code_selector (
  input  annunciator_pkg::display_t                status,
  input  wire logic [annunciator_pkg::WARN_N-1:0]  warn_vec,
  input  wire logic                                reset_warn,
  input  wire logic [annunciator_pkg::ERR_N-1:0]   err_vec,
  output annunciator_pkg::display_t                shown
);

  // Lowest set code number; index 0 is never a code
  function automatic logic [7:0] lowest_code(input logic [63:0] v);
    logic [7:0] n;
    n = 8'h00;
    for (int i = 63; i > 0; i--) begin
      if (v[i]) begin
        n = 8'(i);
      end
    end
    return n;
  endfunction

  always_comb begin
    shown = status;
    if (err_vec != '0) begin
      shown.kind = annunciator_pkg::DISP_ERROR;
      shown.num  = lowest_code(64'(err_vec));
      shown.dot  = 1'b0;
    end else if (warn_vec != '0) begin
      shown.kind = annunciator_pkg::DISP_WARNING;
      shown.num  = lowest_code(64'(warn_vec));
      shown.dot  = 1'b0;
    end else if (reset_warn) begin
      shown.kind = annunciator_pkg::DISP_RESET_IN;
      shown.num  = 8'h00;
      shown.dot  = 1'b0;
    end
  end

endmodule

// file: verification/annunciator_properties.sv
// Port-level assertions for the drive fault annunciator
`timescale 1ns/1ns
module annunciator_properties #(
  parameter int         VERSION_CYCLES = 20,
  parameter logic [7:0] FW_VERSION     = 8'h11
) (
  input wire logic                               clk,
  input wire logic                               reset,
  input wire logic                               reg_rd,
  input wire logic [annunciator_pkg::DATA_W-1:0] reg_rdata,
  input wire logic                               mains_on,
  input wire logic                               enable_in,
  input annunciator_pkg::warn_src_t              warn_src,
  input annunciator_pkg::err_src_t               err_src,
  input annunciator_pkg::display_t               display,
  input wire logic                               drive_enabled,
  input wire logic                               brake_applied,
  input wire logic                               fault_relay_closed
);
  logic [31:0] boot_q;
  // Saturates so a long run cannot wrap back into the boot window
  always_ff @(posedge clk)
    boot_q <= reset ? 32'h00000000 :
      (&boot_q ? boot_q : boot_q + 32'h00000001);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_fault;
    err_src != '0;
  endsequence
  sequence s_shut;
    !fault_relay_closed && !drive_enabled;
  endsequence
  property p_boot;
    boot_q < VERSION_CYCLES - 1 |->
      display.kind == annunciator_pkg::DISP_VERSION && display.num == FW_VERSION;
  endproperty
  a_boot: assert property (p_boot)
    else $error("version not shown during boot");
  property p_boot_end;
    boot_q == VERSION_CYCLES + 3 |->
      display.kind != annunciator_pkg::DISP_VERSION;
  endproperty
  a_boot_end: assert property (p_boot_end)
    else $error("version shown past boot");
  property p_fault;
    s_fault |=> s_shut;
  endproperty
  a_fault: assert property (p_fault)
    else $error("fault left the drive live");
  property p_brake;
    brake_applied != drive_enabled;
  endproperty
  a_brake: assert property (p_brake)
    else $error("brake does not follow drive state");
  property p_enable;
    $rose(drive_enabled) |-> $past(enable_in) && $past(mains_on);
  endproperty
  a_enable: assert property (p_enable)
    else $error("drive enabled without enable and mains");
  property p_rdata;
    !$past(reg_rd) |-> reg_rdata == '0;
  endproperty
  a_rdata: assert property (p_rdata)
    else $error("read data outside its cycle");
  property p_warn_disp;
    warn_src.resp_monitor && err_src == '0 && fault_relay_closed &&
      boot_q > VERSION_CYCLES + 2 |=>
      display.kind == annunciator_pkg::DISP_WARNING && display.num <= 8'h04;
  endproperty
  a_warn_disp: assert property (p_warn_disp)
    else $error("warning code not shown");
  property p_err_disp;
    err_src.heat_sink_ot |-> ##2
      display.kind == annunciator_pkg::DISP_ERROR && display.num == 8'h01;
  endproperty
  a_err_disp: assert property (p_err_disp)
    else $error("heat sink error not shown first");
  property p_code_dot;
    display.kind inside {annunciator_pkg::DISP_WARNING,
      annunciator_pkg::DISP_ERROR} |-> !display.dot;
  endproperty
  a_code_dot: assert property (p_code_dot)
    else $error("dot lit on a code");
endmodule
bind drive_fault_annunciator annunciator_properties #(
  .VERSION_CYCLES(VERSION_CYCLES), .FW_VERSION(FW_VERSION)) i_props (
  .clk(clk), .reset(reset), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .mains_on(mains_on), .enable_in(enable_in), .warn_src(warn_src),
  .err_src(err_src), .display(display), .drive_enabled(drive_enabled),
  .brake_applied(brake_applied), .fault_relay_closed(fault_relay_closed));

// file: verification/enable_controller.sv
// Motion controller model that drives the enable input
`timescale 1ns/1ns
module enable_controller #(
  parameter int SETTLE_CYCLES = 10
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic mains_on,
  input  wire logic want,
  output logic      enable_in
);
  int settle_q = 0;
  always @(posedge clk) begin
    if (reset || !mains_on) begin
      settle_q <= 0;
      enable_in <= 1'b0;
    end else begin
      if (settle_q < SETTLE_CYCLES) settle_q <= settle_q + 1;
      enable_in <= want && (settle_q >= SETTLE_CYCLES);
    end
  end
endmodule

// file: verification/test_drive_fault_annunciator.sv
// Self-checking bench for the drive fault annunciator
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin \
  $display("[ERR] %s expected %h seen %h", nm, ex, gt); err_count++; end end
module test_drive_fault_annunciator;
  localparam int VC = 20;
  localparam int FC = 4;
  localparam int ST = 10;
  // Code of each warning source bit; bit 0 is the reset-input letter
  localparam logic [7:0] WCODE [0:12] = '{8'h00, 8'h20, 8'h0f, 8'h0e,
    8'h0c, 8'h0b, 8'h0a, 8'h09, 8'h08, 8'h07, 8'h06, 8'h05, 8'h04};
  localparam logic [7:0] ECODE [0:5] = '{8'h01, 8'h02, 8'h04, 8'h17,
    8'h03, 8'h05};
  logic clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic mains_on = 1'b0, want = 1'b0, enable_in, drive_enabled;
  logic brake_applied, fault_relay_closed, d0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = '0, reg_rdata, d, rnd = 32'hc755;
  logic [15:0] dc_link_volts = 16'h012c, thr;
  logic [1:0] dig_out;
  annunciator_pkg::meas_t meas = '0;
  annunciator_pkg::warn_src_t warn_src = '0;
  annunciator_pkg::err_src_t err_src = '0;
  annunciator_pkg::display_t display;
  int err_count = 0, check_count = 0;
  always #50 clk = ~clk;
  drive_fault_annunciator #(.VERSION_CYCLES(VC), .FLASH_CYCLES(FC)) i_dut (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mains_on(mains_on), .enable_in(enable_in),
    .dc_link_volts(dc_link_volts), .meas(meas), .warn_src(warn_src),
    .err_src(err_src), .display(display), .drive_enabled(drive_enabled),
    .brake_applied(brake_applied), .fault_relay_closed(fault_relay_closed),
    .dig_out(dig_out));
  enable_controller #(.SETTLE_CYCLES(ST)) i_ctrl (.clk(clk), .reset(reset),
    .mains_on(mains_on), .want(want), .enable_in(enable_in));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [10:0] exp_show(input logic [12:0] w);
    logic [10:0] r;
    r = {annunciator_pkg::DISP_ENABLED, 8'h00};
    if (w[0]) r = {annunciator_pkg::DISP_RESET_IN, 8'h00};
    for (int i = 1; i < 13; i++)
      if (w[i]) r = {annunciator_pkg::DISP_WARNING, WCODE[i]};
    return r;
  endfunction
  function automatic logic [31:0] exp_reg5(input logic [12:0] w);
    logic [31:0] r;
    r = '0;
    for (int i = 1; i < 13; i++) if (w[i]) r[WCODE[i] - 8'h01] = 1'b1;
    return r;
  endfunction
  // Only warning codes keep their number; every other kind is compared by kind
  function automatic logic [10:0] show();
    return {display.kind, display.kind == annunciator_pkg::DISP_WARNING ?
      display.num : 8'h00};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic complete_run();
    if (err_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wait_en();
    int k;
    k = 0;
    while (drive_enabled !== 1'b1 && k < 60) begin tick(1); k++; end
    if (drive_enabled !== 1'b1) begin err_count++; complete_run(); end
  endtask
  task automatic check_warn(input logic [12:0] w);
    @(posedge clk) warn_src <= w;
    tick(2);
    `CHK("warn display", exp_show(w), show())
    rd(annunciator_pkg::REG_WARNINGS, d);
    `CHK("warn reg", exp_reg5(w), d)
    `CHK("warn outs", {2'b11, {2{w != 13'h0000}}}, {drive_enabled, fault_relay_closed, dig_out})
  endtask
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    tick(1);
    `CHK("boot", {annunciator_pkg::DISP_VERSION, 8'h11}, display[11:1])
    `CHK("rst outs", 5'h0c, {drive_enabled, brake_applied,
      fault_relay_closed, dig_out})
    for (int a = 0; a < 16; a++) if (a != 7 && a != 8) begin
      rd(4'(a), d);
      `CHK("reg reset", (a >= 1 && a <= 4) ? 32'hffff : 32'h0, d)
    end
    tick(VC);
    `CHK("rating", {annunciator_pkg::DISP_RATING, 8'h01}, display[11:1])
    d0 = display.dot;
    tick(FC);
    `CHK("dot", ~d0, display.dot)
    @(posedge clk) mains_on <= 1'b1;
    tick(3);
    `CHK("ready", annunciator_pkg::DISP_MAINS_READY, display.kind)
    @(posedge clk) want <= 1'b1;
    wait_en();
    tick(2);
    `CHK("enabled", annunciator_pkg::DISP_ENABLED, display.kind)
    wr(annunciator_pkg::REG_CTRL, 32'h0a);
    rd(annunciator_pkg::REG_CTRL, d);
    `CHK("ctrl", 32'h0a, d)
    for (int i = 0; i < 13; i++) check_warn(13'h1 << i);
    for (int n = 0; n < 20; n++) begin
      rnd = xs(rnd);
      check_warn(rnd[12:0]);
    end
    wr(annunciator_pkg::REG_CTRL, 32'h0b);
    check_warn(13'h0000);
    @(posedge clk) warn_src <= 13'h0800;
    tick(2);
    `CHK("suppress", annunciator_pkg::DISP_ENABLED, display.kind)
    @(posedge clk) warn_src <= '0;
    for (int j = 0; j < 3; j++) begin
      rnd = xs(rnd);
      thr = rnd[15:0] & 16'hfffe;
      wr(4'(j + 1), {16'h0000, thr});
      @(posedge clk) meas <= 48'(thr) << (32 - 16 * j);
      tick(2);
      `CHK("at thr", annunciator_pkg::DISP_ENABLED, display.kind)
      @(posedge clk) meas <= 48'(thr + 16'h0001) << (32 - 16 * j);
      tick(2);
      `CHK("over thr", {annunciator_pkg::DISP_WARNING, 8'(j + 1)}, show())
      @(posedge clk) meas <= '0;
    end
    wr(annunciator_pkg::REG_CTRL, 32'h14);
    wr(annunciator_pkg::REG_LIM_FOLLOW, 32'h0100);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      warn_src <= 13'h1000;
      if (i < 4) err_src <= 4'h8 >> i;
      if (i == 4) meas <= 48'h0101;
      if (i == 5) begin dc_link_volts <= 16'h0032; want <= 1'b0; end
      tick(3);
      if (i == 5) begin @(posedge clk) want <= 1'b1; tick(5); end
      `CHK("err show", {annunciator_pkg::DISP_ERROR, ECODE[i]}, display[11:1])
      `CHK("err outs", 5'h0b, {drive_enabled, brake_applied,
        fault_relay_closed, dig_out})
      rd(annunciator_pkg::REG_ERRORS, d);
      `CHK("err reg", 32'h1 << ECODE[i], d)
      @(posedge clk);
      err_src <= '0; meas <= '0; warn_src <= '0;
      want <= 1'b0; dc_link_volts <= 16'h012c;
      wr(annunciator_pkg::REG_ERRORS, 32'hffffffff);
      rd(annunciator_pkg::REG_ERRORS, d);
      `CHK("err clear", 33'h100000000, {fault_relay_closed, d})
      @(posedge clk) want <= 1'b1;
      wait_en();
    end
    `CHK("dc ok", 1'b1, drive_enabled)
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    complete_run();
  end
endmodule
